// file: verilog/pupg_ctrl.sv
// Profile select, register update, power-down and general-purpose port
//
// Operation
// RULE1: three profile pins select active profile 0 to 7 in binary.
// RULE2: update strobe rising edge copies buffered registers into active ones.
// RULE3: any profile pin change also copies buffered into active registers.
// RULE4: internal update bit turns strobe pin to output, makes own updates.
// RULE5: each internal update drives a twelve-cycle high pulse on the pin.
// RULE6: two-bit rate field divides quarter system clock by 1, 2, 4, 8.
// RULE7: divided clock steps 32-bit counter; period is two-to-A times B.
// RULE8: rate value three or less holds strobe output statically high.
// RULE9: with sleep pin low, four software bits power down four domains.
// RULE10: core power-down blocks writes except one clearing core bit.
// RULE11: sleep pin high powers down all four domains, overriding bits; with the fast-recovery bit set the ref input stays on.
// RULE12: control bit picks full or fast-recovery power-down for sleep pin.
// RULE13: port works only in upconvert mode with two-line serial link.
// RULE14: direction and data bit per pin; 1 output, 0 input.
// RULE15: output pins drive data bit; input pins read back pin level.
// RULE16: port data writes act at once, with no update needed.
// RULE17: pins are synchronised and edges detected to make one-cycle pulse.
`timescale 1ns/100ps
`include "pupg_defs.svh"

module pupg_ctrl (
	input  wire logic                       sys_clk,                 // 25 MHz
	input  wire logic                       sys_rst,                 // Sync
	input  wire logic                       profile_select_bit_zero, // Pin
	input  wire logic                       profile_select_bit_one,  // Pin
	input  wire logic                       profile_select_bit_two,  // Pin
	input  wire logic                       upd_pin_in,              // Pin in
	output logic                            upd_pin_out,             // Pin out
	output logic                            upd_pin_oe_n,            // Low=drive
	input  wire logic                       external_sleep_pin,      // Pin
	input  wire logic                       reg_wr_en,               // Write
	input  wire logic                       reg_rd_en,               // Read
	input  wire pupg_pkg::pupg_addr_type    reg_addr,                // Address
	input  wire pupg_pkg::pupg_word_type    reg_wdata,               // Wr data
	output pupg_pkg::pupg_word_type         reg_rdata,               // Rd data
	output logic                            reg_wr_refused,          // Pulse
	input  wire logic                       quadrature_upconvert_mode, // Mode
	input  wire logic                       serial_data_if_active,   // Link on
	input  wire pupg_pkg::pupg_port_type    port_pin_in,             // Pins in
	output pupg_pkg::pupg_port_type         port_pin_out,            // Pins out
	output pupg_pkg::pupg_port_type         port_pin_oe_n,           // Low=drive
	output pupg_pkg::pupg_profile_type      active_profile,          // Profile
	output logic                            update_xfer,             // Pulse
	output pupg_pkg::pupg_word_type         act_cfg1,                // Active
	output pupg_pkg::pupg_word_type         act_cfg2,                // Active
	output pupg_pkg::pupg_word_type         act_rate,                // Active
	output logic                            pd_core,                 // Core off
	output logic                            pd_main_dac,             // Main off
	output logic                            pd_aux_dac,              // Aux off
	output logic                            pd_ref_input,            // Ref off
	output logic                            pd_bias_pll              // Bias off
);

	import pupg_pkg::*;

	// Pin synchronisation
	logic [20:0]        raw_in;
	logic [20:0]        synced;
	pupg_profile_type   prof_s;
	logic               upd_s;
	logic               sleep_s;
	pupg_port_type      pin_s;

	assign raw_in = {port_pin_in, external_sleep_pin, upd_pin_in,
		profile_select_bit_two, profile_select_bit_one,
		profile_select_bit_zero};

	pupg_sync2 #(
		.WIDTH    (21)
	) u_sync (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (raw_in),
		.sync_out (synced)
	); // [RULE17]

	assign prof_s  = synced[2:0];
	assign upd_s   = synced[3];
	assign sleep_s = synced[4];
	assign pin_s   = synced[20:5];

	// Edge history
	pupg_profile_type   prof_prev_q;
	pupg_profile_type   prof_prev_d;
	logic               upd_prev_q;
	logic               upd_prev_d;

	always_comb begin
		prof_prev_d = prof_s;
		upd_prev_d  = upd_s;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prof_prev_q <= 3'h0;
			upd_prev_q  <= 1'b0;
		end else begin
			prof_prev_q <= prof_prev_d;
			upd_prev_q  <= upd_prev_d;
		end
	end

	// Update engine
	pupg_upd_state_type state_q;
	pupg_upd_state_type state_d;
	logic [5:0]         presc_q;
	logic [5:0]         presc_d;
	pupg_word_type      cnt_q;
	pupg_word_type      cnt_d;
	logic [3:0]         pulse_q;
	logic [3:0]         pulse_d;
	logic [5:0]         div_len;
	logic               tick;
	logic               int_fire;
	logic               int_en;
	logic               rate_static;
	logic               ext_rise;
	logic               prof_chg;
	logic               xfer;
	pupg_word_type      act_cfg1_q;
	pupg_word_type      act_cfg2_q;
	pupg_word_type      act_rate_q;

	assign int_en      = act_cfg2_q[`PUPG_CFG2_INT_UPD];
	assign rate_static = (act_rate_q <= `PUPG_STATIC_MAX);
	// Quarter-rate clock, further divided by 2^A
	assign div_len = `PUPG_QUARTER_DIV <<
		act_cfg2_q[`PUPG_CFG2_RATE_HI:`PUPG_CFG2_RATE_LO]; // [RULE6]
	assign tick = (presc_q == div_len - 6'h01);
	assign ext_rise = (state_q == UPD_EXT) && upd_s && !upd_prev_q; // [RULE2]
	assign prof_chg = (prof_s != prof_prev_q); // [RULE3]
	assign xfer     = ext_rise || prof_chg || int_fire; // [RULE17]

	always_comb begin
		state_d  = state_q;
		presc_d  = 6'h00;
		cnt_d    = cnt_q;
		pulse_d  = pulse_q;
		int_fire = 1'b0;
		case (state_q)
			UPD_EXT: begin
				cnt_d = act_rate_q;
				if (int_en) begin // [RULE4]
					state_d = rate_static ? UPD_HIGH : UPD_WAIT;
				end
			end
			UPD_WAIT, UPD_PULSE: begin
				if (!int_en) begin
					state_d = UPD_EXT;
				end else if (rate_static) begin
					state_d = UPD_HIGH; // [RULE8]
				end else begin
					presc_d = tick ? 6'h00 : presc_q + 6'h01;
					if (state_q == UPD_PULSE) begin
						if (pulse_q == 4'h0) begin
							state_d = UPD_WAIT;
						end else begin
							pulse_d = pulse_q - 4'h1;
						end
					end
					// Each tick is worth four system-clock counts of B
					if (tick) begin // [RULE7]
						if (cnt_q <= `PUPG_COUNT_STEP) begin
							int_fire = 1'b1;
							cnt_d    = act_rate_q;
							state_d  = UPD_PULSE;
							pulse_d  = 4'(`PUPG_PULSE_CYC - 1); // [RULE5]
						end else begin
							cnt_d = cnt_q - `PUPG_COUNT_STEP;
						end
					end
				end
			end
			UPD_HIGH: begin
				cnt_d = act_rate_q;
				if (!int_en) begin
					state_d = UPD_EXT;
				end else if (!rate_static) begin
					state_d = UPD_WAIT;
				end
			end
			default: begin
				state_d = UPD_EXT;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= UPD_EXT;
			presc_q <= 6'h00;
			cnt_q   <= `PUPG_RATE_RST;
			pulse_q <= 4'h0;
		end else begin
			state_q <= state_d;
			presc_q <= presc_d;
			cnt_q   <= cnt_d;
			pulse_q <= pulse_d;
		end
	end

	// Registers: buffered, active and port
	pupg_word_type      buf_cfg1_q;
	pupg_word_type      buf_cfg1_d;
	pupg_word_type      buf_cfg2_q;
	pupg_word_type      buf_cfg2_d;
	pupg_word_type      buf_rate_q;
	pupg_word_type      buf_rate_d;
	pupg_word_type      act_cfg1_d;
	pupg_word_type      act_cfg2_d;
	pupg_word_type      act_rate_d;
	pupg_port_type      port_dir_q;
	pupg_port_type      port_dir_d;
	pupg_port_type      port_data_q;
	pupg_port_type      port_data_d;
	pupg_word_type      rdata_q;
	pupg_word_type      rdata_d;
	logic               refused_q;
	logic               refused_d;
	logic               pd_core_q;
	logic               wake_wr;
	logic               wr_ok;
	pupg_port_type      port_read;

	// A write clearing the core bit must always land, else no way back
	assign wake_wr = (reg_addr == `PUPG_ADDR_CFG1) &&
		!reg_wdata[`PUPG_CFG1_PD_CORE];
	assign wr_ok = reg_wr_en && (!pd_core_q || wake_wr); // [RULE10]
	assign port_read = (port_data_q & port_dir_q) |
		(pin_s & ~port_dir_q); // [RULE15]

	always_comb begin
		buf_cfg1_d  = buf_cfg1_q;
		buf_cfg2_d  = buf_cfg2_q;
		buf_rate_d  = buf_rate_q;
		port_dir_d  = port_dir_q;
		port_data_d = port_data_q;
		if (wr_ok) begin
			if (reg_addr == `PUPG_ADDR_CFG1) begin
				buf_cfg1_d = reg_wdata;
			end else if (reg_addr == `PUPG_ADDR_CFG2) begin
				buf_cfg2_d = reg_wdata;
			end else if (reg_addr == `PUPG_ADDR_RATE) begin
				buf_rate_d = reg_wdata;
			end else if (reg_addr == `PUPG_ADDR_PORT_DIR) begin
				port_dir_d = reg_wdata[15:0]; // [RULE14]
			end else if (reg_addr == `PUPG_ADDR_PORT_DATA) begin
				port_data_d = reg_wdata[15:0]; // [RULE16]
			end
		end
		act_cfg1_d = act_cfg1_q;
		act_cfg2_d = act_cfg2_q;
		act_rate_d = act_rate_q;
		if (xfer) begin // [RULE2]
			act_cfg1_d = buf_cfg1_d;
			act_cfg2_d = buf_cfg2_d;
			act_rate_d = buf_rate_d;
		end
		// Waking the core bypasses the update so the core can run again
		if (pd_core_q && wr_ok) begin // [RULE10]
			act_cfg1_d[`PUPG_CFG1_PD_CORE] = 1'b0;
		end
		refused_d = reg_wr_en && !wr_ok;
		rdata_d   = rdata_q;
		if (reg_rd_en) begin
			if (reg_addr == `PUPG_ADDR_CFG1) begin
				rdata_d = buf_cfg1_q;
			end else if (reg_addr == `PUPG_ADDR_CFG2) begin
				rdata_d = buf_cfg2_q;
			end else if (reg_addr == `PUPG_ADDR_RATE) begin
				rdata_d = buf_rate_q;
			end else if (reg_addr == `PUPG_ADDR_PORT_DIR) begin
				rdata_d = {16'h0000, port_dir_q};
			end else if (reg_addr == `PUPG_ADDR_PORT_DATA) begin
				rdata_d = {16'h0000, port_read};
			end else begin
				rdata_d = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			buf_cfg1_q  <= `PUPG_CFG1_RST;
			buf_cfg2_q  <= `PUPG_CFG2_RST;
			buf_rate_q  <= `PUPG_RATE_RST;
			act_cfg1_q  <= `PUPG_CFG1_RST;
			act_cfg2_q  <= `PUPG_CFG2_RST;
			act_rate_q  <= `PUPG_RATE_RST;
			port_dir_q  <= `PUPG_PORT_DIR_RST;
			port_data_q <= `PUPG_PORT_DATA_RST;
			rdata_q     <= 32'h0000_0000;
			refused_q   <= 1'b0;
		end else begin
			buf_cfg1_q  <= buf_cfg1_d;
			buf_cfg2_q  <= buf_cfg2_d;
			buf_rate_q  <= buf_rate_d;
			act_cfg1_q  <= act_cfg1_d;
			act_cfg2_q  <= act_cfg2_d;
			act_rate_q  <= act_rate_d;
			port_dir_q  <= port_dir_d;
			port_data_q <= port_data_d;
			rdata_q     <= rdata_d;
			refused_q   <= refused_d;
		end
	end

	// Output stage
	logic               fast_rec;
	logic               gp_en;
	logic               pd_core_d;
	logic               pd_main_q;
	logic               pd_main_d;
	logic               pd_aux_q;
	logic               pd_aux_d;
	logic               pd_ref_q;
	logic               pd_ref_d;
	logic               pd_bias_q;
	logic               pd_bias_d;
	logic               upd_out_q;
	logic               upd_out_d;
	logic               upd_oe_n_q;
	logic               upd_oe_n_d;
	pupg_port_type      pin_out_q;
	pupg_port_type      pin_out_d;
	pupg_port_type      pin_oe_n_q;
	pupg_port_type      pin_oe_n_d;
	pupg_profile_type   profile_q;
	pupg_profile_type   profile_d;
	logic               xfer_q;
	logic               xfer_d;

	assign fast_rec = act_cfg1_q[`PUPG_CFG1_EXT_FAST];
	assign gp_en    = quadrature_upconvert_mode && serial_data_if_active;

	always_comb begin
		if (sleep_s) begin // [RULE11]
			pd_core_d = 1'b1;
			pd_main_d = 1'b1;
			pd_aux_d  = 1'b1;
			pd_ref_d  = !fast_rec; // [RULE12]
			pd_bias_d = !fast_rec;
		end else begin // [RULE9]
			pd_core_d = act_cfg1_d[`PUPG_CFG1_PD_CORE];
			pd_main_d = act_cfg1_d[`PUPG_CFG1_PD_MAIN];
			pd_aux_d  = act_cfg1_d[`PUPG_CFG1_PD_AUX];
			pd_ref_d  = act_cfg1_d[`PUPG_CFG1_PD_REF];
			pd_bias_d = 1'b0;
		end
		upd_out_d  = (state_d == UPD_PULSE) || (state_d == UPD_HIGH); // [RULE5]
		upd_oe_n_d = (state_d == UPD_EXT); // [RULE4]
		pin_out_d  = port_data_d;
		pin_oe_n_d = gp_en ? ~port_dir_d : 16'hffff; // [RULE13]
		profile_d  = prof_s; // [RULE1]
		xfer_d     = xfer;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pd_core_q  <= 1'b0;
			pd_main_q  <= 1'b0;
			pd_aux_q   <= 1'b0;
			pd_ref_q   <= 1'b0;
			pd_bias_q  <= 1'b0;
			upd_out_q  <= 1'b0;
			upd_oe_n_q <= 1'b1;
			pin_out_q  <= 16'h0000;
			pin_oe_n_q <= 16'hffff;
			profile_q  <= 3'h0;
			xfer_q     <= 1'b0;
		end else begin
			pd_core_q  <= pd_core_d;
			pd_main_q  <= pd_main_d;
			pd_aux_q   <= pd_aux_d;
			pd_ref_q   <= pd_ref_d;
			pd_bias_q  <= pd_bias_d;
			upd_out_q  <= upd_out_d;
			upd_oe_n_q <= upd_oe_n_d;
			pin_out_q  <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
			profile_q  <= profile_d;
			xfer_q     <= xfer_d;
		end
	end

	assign upd_pin_out    = upd_out_q;
	assign upd_pin_oe_n   = upd_oe_n_q;
	assign reg_rdata      = rdata_q;
	assign reg_wr_refused = refused_q;
	assign port_pin_out   = pin_out_q;
	assign port_pin_oe_n  = pin_oe_n_q;
	assign active_profile = profile_q;
	assign update_xfer    = xfer_q;
	assign act_cfg1       = act_cfg1_q;
	assign act_cfg2       = act_cfg2_q;
	assign act_rate       = act_rate_q;
	assign pd_core        = pd_core_q;
	assign pd_main_dac    = pd_main_q;
	assign pd_aux_dac     = pd_aux_q;
	assign pd_ref_input   = pd_ref_q;
	assign pd_bias_pll    = pd_bias_q;

endmodule // pupg_ctrl

// file: verilog/pupg_defs.svh
// Register addresses, field positions, reset values and timing constants
`ifndef PUPG_DEFS_SVH
`define PUPG_DEFS_SVH

// Serial-port side register addresses
`define PUPG_ADDR_CFG1        8'h00
`define PUPG_ADDR_CFG2        8'h01
`define PUPG_ADDR_RATE        8'h04
`define PUPG_ADDR_PORT_DIR    8'h05
`define PUPG_ADDR_PORT_DATA   8'h06

// config_register_one fields
`define PUPG_CFG1_PD_CORE     7
`define PUPG_CFG1_PD_MAIN     6
`define PUPG_CFG1_PD_AUX      5
`define PUPG_CFG1_PD_REF      4
`define PUPG_CFG1_EXT_FAST    3

// config_register_two fields
`define PUPG_CFG2_INT_UPD     23
`define PUPG_CFG2_RATE_HI     15
`define PUPG_CFG2_RATE_LO     14

// Reset values
`define PUPG_CFG1_RST         32'h0000_0000
`define PUPG_CFG2_RST         32'h0000_0000
`define PUPG_RATE_RST         32'h0000_ffff
`define PUPG_PORT_DIR_RST     16'h0000
`define PUPG_PORT_DATA_RST    16'h0000

// Timing
`define PUPG_CLK_NS           40
`define PUPG_PULSE_NS         480
`define PUPG_PULSE_CYC        (`PUPG_PULSE_NS / `PUPG_CLK_NS)
`define PUPG_QUARTER_DIV      6'h04
`define PUPG_COUNT_STEP       32'h0000_0004
`define PUPG_STATIC_MAX       32'h0000_0003

`endif

// file: verilog/pupg_pkg.sv
// Types shared by the profile, update, power and port control block
package pupg_pkg;

	typedef logic [7:0]  pupg_addr_type;
	typedef logic [31:0] pupg_word_type;
	typedef logic [15:0] pupg_port_type;
	typedef logic [2:0]  pupg_profile_type;

	typedef enum logic [3:0] {
		UPD_EXT   = 4'b0001,
		UPD_WAIT  = 4'b0010,
		UPD_PULSE = 4'b0100,
		UPD_HIGH  = 4'b1000
	} pupg_upd_state_type;

endpackage

// file: verilog/pupg_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps

module pupg_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,  // System clock
	input  wire logic             sys_rst,  // Synchronous reset
	input  wire logic [WIDTH-1:0] async_in, // Raw pin levels
	output logic      [WIDTH-1:0] sync_out  // Synchronised levels
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule // pupg_sync2

// file: tb/pupg_props.sv
// Port-level assertions for the control block
`timescale 1ns/100ps

module pupg_props (
	input logic                   sys_clk,                   // Clock
	input logic                   sys_rst,                   // Reset
	input logic                   profile_select_bit_zero,   // Pin
	input logic                   profile_select_bit_one,    // Pin
	input logic                   profile_select_bit_two,    // Pin
	input logic                   upd_pin_out,               // Strobe out
	input logic                   upd_pin_oe_n,              // Strobe oe
	input logic                   external_sleep_pin,        // Pin
	input logic                   reg_wr_en,                 // Write
	input pupg_pkg::pupg_addr_type reg_addr,                  // Address
	input pupg_pkg::pupg_word_type reg_wdata,                 // Data
	input logic                   reg_wr_refused,            // Refused
	input logic                   quadrature_upconvert_mode, // Mode
	input logic                   serial_data_if_active,     // Link
	input pupg_pkg::pupg_port_type port_pin_out,              // Port out
	input pupg_pkg::pupg_port_type port_pin_oe_n,             // Port oe
	input pupg_pkg::pupg_profile_type active_profile,         // Profile
	input logic                   update_xfer,               // Transfer
	input pupg_pkg::pupg_word_type act_cfg1,                  // Active
	input pupg_pkg::pupg_word_type act_cfg2,                  // Active
	input pupg_pkg::pupg_word_type act_rate,                  // Active
	input logic                   pd_core,                   // Off
	input logic                   pd_main_dac,               // Off
	input logic                   pd_aux_dac,                // Off
	input logic                   pd_ref_input,              // Off
	input logic                   pd_bias_pll                // Off
);
	import pupg_pkg::*;
	logic [2:0] pins;
	logic [4:0] hi_cnt_q;
	logic [4:0] hi_cnt_d;
	assign pins = {profile_select_bit_two, profile_select_bit_one,
		profile_select_bit_zero};
	// Counts high samples so the pulse width can be judged at its end
	always_comb hi_cnt_d = upd_pin_out ? hi_cnt_q + 5'h01 : 5'h00;
	always_ff @(posedge sys_clk) hi_cnt_q <= sys_rst ? 5'h00 : hi_cnt_d;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	profile_map_a: assert property ($stable(pins)[*4] |-> active_profile == pins)
		else $error("active profile differs from pins");
	rate_load_a: assert property ($changed(act_rate) |-> update_xfer)
		else $error("active rate changed without transfer pulse");
	oe_mode_a: assert property ($stable(act_cfg2)[*2] |-> upd_pin_oe_n == !act_cfg2[23])
		else $error("strobe direction does not follow mode");
	pulse_width_a: assert property ($fell(upd_pin_out) && !upd_pin_oe_n && act_rate > 32'h00000040 |-> hi_cnt_q == 5'h0c)
		else $error("internal strobe pulse width wrong");
	static_high_a: assert property ((!upd_pin_oe_n && act_rate <= 32'h00000003)[*4] |-> upd_pin_out)
		else $error("strobe not static high for small rate");
	soft_pd_a: assert property ((!external_sleep_pin && $stable(act_cfg1))[*4] |-> pd_aux_dac == act_cfg1[5])
		else $error("aux power-down does not follow bit");
	refuse_a: assert property (pd_core && reg_wr_en && (reg_addr != 8'h00 || reg_wdata[7]) |=> reg_wr_refused)
		else $error("write during core power-down not refused");
	wake_a: assert property (pd_core && reg_wr_en && reg_addr == 8'h00 && !reg_wdata[7] |=> !reg_wr_refused)
		else $error("wake write refused");
	sleep_all_a: assert property (external_sleep_pin[*4] |=> pd_core && pd_main_dac && pd_aux_dac)
		else $error("sleep pin did not power down");
	sleep_full_a: assert property ((external_sleep_pin && !act_cfg1[3])[*4] |=> pd_ref_input && pd_bias_pll)
		else $error("full sleep kept reference powered");
	port_off_a: assert property (!(quadrature_upconvert_mode && serial_data_if_active) |=> port_pin_oe_n == 16'hffff)
		else $error("port driven outside its mode");
	port_out_a: assert property (reg_wr_en && !pd_core && reg_addr == 8'h06 |=> {16'h0000, port_pin_out} == ($past(reg_wdata) & 32'h0000ffff))
		else $error("port data write not immediate");
endmodule // pupg_props

bind pupg_ctrl pupg_props u_props (.sys_clk, .sys_rst, .profile_select_bit_zero,
	.profile_select_bit_one, .profile_select_bit_two, .upd_pin_out,
	.upd_pin_oe_n, .external_sleep_pin, .reg_wr_en, .reg_addr, .reg_wdata,
	.reg_wr_refused, .quadrature_upconvert_mode, .serial_data_if_active,
	.port_pin_out, .port_pin_oe_n, .active_profile, .update_xfer, .act_cfg1,
	.act_cfg2, .act_rate, .pd_core, .pd_main_dac, .pd_aux_dac, .pd_ref_input,
	.pd_bias_pll);

// file: tb/pupg_ext_ctl.sv
// Model of the external controller on profile, strobe and sleep pins
`timescale 1ns/100ps

module pupg_ext_ctl (
	input  wire logic sys_clk,                 // Clock
	input  wire logic upd_pin_out,             // Device strobe level
	input  wire logic upd_pin_oe_n,            // Low while device drives
	output logic      profile_select_bit_zero, // Pin
	output logic      profile_select_bit_one,  // Pin
	output logic      profile_select_bit_two,  // Pin
	output logic      upd_pin_in,              // Resolved strobe wire
	output logic      external_sleep_pin       // Pin
);
	logic [2:0] prof_q = 3'h0;
	logic       strobe_q = 1'b0;
	logic       sleep_q = 1'b0;
	assign {profile_select_bit_two, profile_select_bit_one,
		profile_select_bit_zero} = prof_q;
	// Controller lets go of the line while the device drives it
	assign upd_pin_in = upd_pin_oe_n ? strobe_q : upd_pin_out;
	assign external_sleep_pin = sleep_q;

	task automatic set_profile(input logic [2:0] p);
		@(posedge sys_clk);
		#1 prof_q = p;
	endtask

	// Held three cycles so the synchroniser cannot miss it
	task automatic pulse_update();
		@(posedge sys_clk);
		#1 strobe_q = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 strobe_q = 1'b0;
	endtask

	task automatic set_sleep(input logic s);
		@(posedge sys_clk);
		#1 sleep_q = s;
	endtask
endmodule // pupg_ext_ctl

// file: tb/tb_profile_update_power_gpio_ctrl.sv
// Self-checking testbench for the control block
`timescale 1ns/100ps
`include "pupg_defs.svh"

module tb_profile_update_power_gpio_ctrl;
	import pupg_pkg::*;
	logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
	logic quadrature_upconvert_mode = 1'b1, serial_data_if_active = 1'b1;
	pupg_addr_type reg_addr = 8'h00;
	pupg_word_type reg_wdata = 32'h0, reg_rdata, act_cfg1, act_cfg2, act_rate;
	pupg_port_type port_drv = 16'h0000, port_pin_in, port_pin_out, port_pin_oe_n;
	pupg_profile_type active_profile;
	logic profile_select_bit_zero, profile_select_bit_one, profile_select_bit_two;
	logic upd_pin_in, upd_pin_out, upd_pin_oe_n, external_sleep_pin;
	logic reg_wr_refused, update_xfer, refused;
	logic pd_core, pd_main_dac, pd_aux_dac, pd_ref_input, pd_bias_pll;
	int errors = 0, total_checks = 0, xfers = 0;
	pupg_word_type v;

	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (update_xfer === 1'b1) xfers++;
	assign port_pin_in = (port_pin_out & ~port_pin_oe_n) | (port_drv & port_pin_oe_n);

	pupg_ctrl DUT (.sys_clk, .sys_rst, .profile_select_bit_zero,
		.profile_select_bit_one, .profile_select_bit_two, .upd_pin_in,
		.upd_pin_out, .upd_pin_oe_n, .external_sleep_pin, .reg_wr_en,
		.reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_wr_refused,
		.quadrature_upconvert_mode, .serial_data_if_active, .port_pin_in,
		.port_pin_out, .port_pin_oe_n, .active_profile, .update_xfer,
		.act_cfg1, .act_cfg2, .act_rate, .pd_core, .pd_main_dac, .pd_aux_dac,
		.pd_ref_input, .pd_bias_pll);
	pupg_ext_ctl u_ctl (.sys_clk, .upd_pin_out, .upd_pin_oe_n,
		.profile_select_bit_zero, .profile_select_bit_one,
		.profile_select_bit_two, .upd_pin_in, .external_sleep_pin);

	task automatic tally_and_finish();
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input pupg_addr_type a, input pupg_word_type d);
		@(posedge sys_clk);
		#1 reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge sys_clk);
		#1 reg_wr_en = 1'b0;
		refused = reg_wr_refused;
		@(posedge sys_clk);
		#1 refused = refused | reg_wr_refused;
	endtask

	task automatic rd(input pupg_addr_type a, output pupg_word_type d);
		@(posedge sys_clk);
		#1 reg_rd_en = 1'b1;
		reg_addr = a;
		@(posedge sys_clk);
		#1 reg_rd_en = 1'b0;
		@(posedge sys_clk);
		#1 d = reg_rdata;
	endtask

	// Cycles from the call to the next rising strobe output
	task automatic wait_rise(output int n);
		n = 0;
		while (upd_pin_out === 1'b1 && n < 3000) begin
			@(posedge sys_clk);
			#1 n++;
		end
		while (upd_pin_out !== 1'b1 && n < 3000) begin
			@(posedge sys_clk);
			#1 n++;
		end
	endtask

	task automatic t_reset();
		rd(`PUPG_ADDR_CFG1, v); check("cfg1", v, `PUPG_CFG1_RST);
		rd(`PUPG_ADDR_CFG2, v); check("cfg2", v, `PUPG_CFG2_RST);
		rd(`PUPG_ADDR_RATE, v); check("rate", v, `PUPG_RATE_RST);
		rd(`PUPG_ADDR_PORT_DIR, v); check("dir", v, 32'h0);
		rd(8'h7f, v); check("unmapped", v, 32'h0);
	endtask

	task automatic t_update();
		int n;
		wr(`PUPG_ADDR_RATE, 32'h00001234);
		wt(8);
		check("rate early", act_rate, `PUPG_RATE_RST);
		n = xfers;
		u_ctl.pulse_update();
		wt(8);
		check("rate", act_rate, 32'h00001234);
		check("xfer count", xfers - n, 1);
	endtask

	task automatic t_profile();
		int n;
		wr(`PUPG_ADDR_CFG1, 32'h00000040);
		for (int i = 1; i < 9; i++) begin
			n = xfers;
			u_ctl.set_profile(i[2:0]);
			wt(8);
			check("profile", active_profile, i[2:0]);
			check("profile xfer", xfers - n, 1);
		end
		check("cfg1 via profile", act_cfg1, 32'h00000040);
	endtask

	task automatic t_power();
		for (int b = 4; b < 8; b++) begin
			wr(`PUPG_ADDR_CFG1, 32'h1 << b);
			u_ctl.pulse_update();
			wt(8);
			check("pd bits", {pd_core, pd_main_dac, pd_aux_dac, pd_ref_input}, 4'h1 << (b - 4));
		end
		wr(`PUPG_ADDR_RATE, 32'h00000777);
		check("refused", refused, 1'b1);
		wr(`PUPG_ADDR_CFG1, 32'h0);
		check("wake refused", refused, 1'b0);
		wt(4);
		check("core awake", pd_core, 1'b0);
		rd(`PUPG_ADDR_RATE, v); check("rate kept", v, 32'h00001234);
		u_ctl.set_sleep(1'b1);
		wt(8);
		check("full sleep", {pd_core, pd_main_dac, pd_aux_dac, pd_ref_input, pd_bias_pll}, 5'h1f);
		wr(`PUPG_ADDR_CFG1, 32'h00000008);
		u_ctl.pulse_update();
		wt(8);
		check("fast sleep", {pd_core, pd_main_dac, pd_aux_dac, pd_ref_input, pd_bias_pll}, 5'h1c);
		u_ctl.set_sleep(1'b0);
		wr(`PUPG_ADDR_CFG1, 32'h0);
		u_ctl.pulse_update();
		wt(8);
		check("awake", {pd_core, pd_main_dac, pd_aux_dac, pd_ref_input, pd_bias_pll}, 5'h00);
	endtask

	task automatic t_gpio();
		port_drv = 16'h0f0f;
		wr(`PUPG_ADDR_PORT_DIR, 32'h000000f0);
		wr(`PUPG_ADDR_PORT_DATA, 32'h00005a5a);
		check("port out", port_pin_out, 16'h5a5a);
		check("port oe", port_pin_oe_n, 16'hff0f);
		wt(4);
		rd(`PUPG_ADDR_PORT_DATA, v);
		check("port read", v, 32'h00000f5f);
		serial_data_if_active = 1'b0;
		wt(2);
		check("port off", port_pin_oe_n, 16'hffff);
		serial_data_if_active = 1'b1;
		quadrature_upconvert_mode = 1'b0;
		wt(2);
		check("port off mode", port_pin_oe_n, 16'hffff);
		quadrature_upconvert_mode = 1'b1;
		wt(2);
		check("port on", port_pin_oe_n, 16'hff0f);
	endtask

	task automatic t_internal();
		int n;
		wr(`PUPG_ADDR_RATE, 32'h00000050);
		for (int a = 0; a < 4; a++) begin
			wr(`PUPG_ADDR_CFG2, 32'h00800000 | (a << 14));
			if (a == 0) u_ctl.pulse_update();
			wt(6);
			check("strobe oe", upd_pin_oe_n, 1'b0);
			wait_rise(n);
			wait_rise(n);
			check("period", n, 32'h50 << a);
			check("cfg2 active", act_cfg2, 32'h00800000 | (a << 14));
		end
		wr(`PUPG_ADDR_RATE, 32'h00000002);
		wait_rise(n);
		wt(200);
		check("static high", upd_pin_out, 1'b1);
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		tally_and_finish();
	end

	initial begin
		repeat (8) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		t_reset();
		t_update();
		t_profile();
		t_power();
		t_gpio();
		t_internal();
		tally_and_finish();
	end
endmodule // tb_profile_update_power_gpio_ctrl
